// file: rtl/smc_device.sv
// serial memory device end: opcode decode, status register, array
// Overview of operation
// R1: nine opcodes, eight bits first after select; device decodes seven, ID read and sleep go to ignore
// R2: fixed opcode values; host sends only those
// R3: select rise mid-opcode executes nothing
// R4: bit7 protect enable, gates status writes
// R5: bits 6..4 plain stored bits
// R6: bits 3..2 choose protected array region
// R7: latch set only by its set command
// R8: latch clears at reset, reset cmd, write end
// R9: bit0 reads zero always
// R10: host sets latch before any write
// R11: latch clear blocks all writes
// R12: status read shifts out eight bits
// R13: status repeats while clocking continues
// R14: status write takes eight bits, drops 1..0
// R15: host holds protect pin steady during write
// R16: read takes 24-bit address, upper ignored
// R17: reads increment and wrap to zero
// R18: write commits each full byte
// R19: writes increment and wrap to zero
// R20: fast read skips eight dummy bits
// R21: sample on rising, drive on falling
// R22: protect bits decode none/quarter/half/all
// R23: status writable unless enable and pin low
// R24: unknown opcode ignored, output released
//
// Implementation choices: the APB register port and the address map.
module smc_device
   import smc_pkg::*;
#(
   parameter int DEPTH = 131072
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // link
   smc_link_if.device link,
   // user side
   output logic [7:0] status_view,
   output logic busy
);
   import smc_pkg::*;

   typedef enum logic [2:0] {
      SMC_OPCODE = 3'b000,
      SMC_ADDR = 3'b001,
      SMC_DUMMY = 3'b010,
      SMC_RDATA = 3'b011,
      SMC_WDATA = 3'b100,
      SMC_STREAD = 3'b101,
      SMC_STWRITE = 3'b110,
      SMC_IGNORE = 3'b111
   } smc_dev_e;

   // ******************************
   // pin synchronisers
   // ******************************
   // third stage only where an edge is needed
   logic [2:0] sel_sync, sck_sync;
   logic [1:0] mosi_sync, prot_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_sync <= 3'h7;
         sck_sync <= 3'h0;
         mosi_sync <= 2'h0;
         prot_sync <= 2'h3;
      end else if (clk_en) begin
         sel_sync <= {sel_sync[1:0], link.sel_n};
         sck_sync <= {sck_sync[1:0], link.sck};
         mosi_sync <= {mosi_sync[0], link.mosi};
         prot_sync <= {prot_sync[0], link.protect_n};
      end
   end
   wire sel_n_s = sel_sync[1];
   wire sck_s = sck_sync[1];
   wire mosi_s = mosi_sync[1];
   wire prot_s = prot_sync[1];
   // R21 edge find
   wire sck_rise = sck_s & ~sck_sync[2] & ~sel_n_s;
   wire sck_fall = ~sck_s & sck_sync[2] & ~sel_n_s;
   wire sel_rise = sel_n_s & ~sel_sync[2];

   // ******************************
   // state
   // ******************************
   smc_dev_e state;
   logic [2:0] bitcnt;
   logic [7:0] shreg;
   logic [1:0] bytecnt;
   logic [ADDR_W-1:0] addr;
   logic [7:0] opcode;
   logic [7:0] status_nv;
   logic latch;
   logic write_seen;
   logic [7:0] txreg;
   logic miso_q, miso_oe_q;
   logic [7:0] mem [0:DEPTH-1];

   wire [7:0] next_byte = {shreg[6:0], mosi_s};
   wire byte_done = sck_rise & (bitcnt == 3'h7);
   // R9 bit zero forced
   wire [7:0] status_rd = {status_nv[7:2], latch, 1'b0};
   // R22 region decode
   wire [1:0] bp = {status_nv[ST_BP_HI], status_nv[ST_BP_LO]};
   wire in_prot = (bp == 2'b11) | ((bp == 2'b10) & (addr >= ADDR_HALF))
      | ((bp == 2'b01) & (addr >= ADDR_QUARTER));
   // R23 R11 write gates
   wire st_wr_ok = latch & ~(status_nv[ST_PROTECT_EN] & ~prot_s);
   wire mem_wr_ok = latch & ~in_prot;
   wire [ADDR_W-1:0] addr_inc = (addr == ADDR_W'(DEPTH - 1)) ? '0 : addr + 1'b1;
   wire is_read = (opcode == OP_MEM_READ) | (opcode == OP_FAST_READ);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SMC_OPCODE;
         bitcnt <= 3'h0;
         shreg <= 8'h00;
         bytecnt <= 2'h0;
         addr <= '0;
         opcode <= 8'h00;
         status_nv <= ST_RESET;
         // R8 power-on clear
         latch <= 1'b0;
         write_seen <= 1'b0;
         txreg <= 8'h00;
         miso_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else if (clk_en) begin
         if (sel_n_s) begin
            // R3 abort on deselect
            state <= SMC_OPCODE;
            bitcnt <= 3'h0;
            bytecnt <= 2'h0;
            miso_oe_q <= 1'b0;
            // R8 clear at write end
            if (sel_rise && write_seen) latch <= 1'b0;
            write_seen <= 1'b0;
         end else begin
            if (sck_rise) begin
               bitcnt <= bitcnt + 3'h1;
               shreg <= next_byte;
            end
            if (byte_done) begin
               case (state)
                  // R1 R2 opcode decode
                  SMC_OPCODE: begin
                     opcode <= next_byte;
                     bytecnt <= 2'h0;
                     case (next_byte)
                        // R7 latch commands
                        OP_LATCH_SET: begin
                           latch <= 1'b1;
                           state <= SMC_IGNORE;
                        end
                        OP_LATCH_RESET: begin
                           latch <= 1'b0;
                           state <= SMC_IGNORE;
                        end
                        OP_STATUS_READ: begin
                           state <= SMC_STREAD;
                           txreg <= status_rd;
                        end
                        OP_STATUS_WRITE: begin
                           state <= SMC_STWRITE;
                           write_seen <= 1'b1;
                        end
                        OP_MEM_READ, OP_FAST_READ: state <= SMC_ADDR;
                        OP_MEM_WRITE: begin
                           state <= SMC_ADDR;
                           write_seen <= 1'b1;
                        end
                        // R24 unknown ignored
                        default: state <= SMC_IGNORE;
                     endcase
                  end
                  // R16 address, upper bits dropped
                  SMC_ADDR: begin
                     addr <= {addr[ADDR_W-9:0], next_byte};
                     bytecnt <= bytecnt + 2'h1;
                     if (bytecnt == 2'(ADDR_BYTES - 1)) begin
                        if (opcode == OP_FAST_READ) state <= SMC_DUMMY;
                        else if (is_read) begin
                           state <= SMC_RDATA;
                           txreg <= mem[{addr[ADDR_W-9:0], next_byte}];
                        end else state <= SMC_WDATA;
                     end
                  end
                  // R20 dummy byte skipped
                  SMC_DUMMY: begin
                     state <= SMC_RDATA;
                     txreg <= mem[addr];
                  end
                  // R17 next byte, wrap
                  SMC_RDATA: begin
                     addr <= addr_inc;
                     txreg <= mem[addr_inc];
                  end
                  // R18 R19 commit and advance
                  SMC_WDATA: begin
                     if (mem_wr_ok) mem[addr] <= next_byte;
                     addr <= addr_inc;
                  end
                  // R13 reload status
                  SMC_STREAD: txreg <= status_rd;
                  // R14 R4 R5 R6 status write
                  SMC_STWRITE: begin
                     if (st_wr_ok) status_nv <= next_byte & ST_NV_MASK;
                     state <= SMC_IGNORE;
                  end
                  default: state <= SMC_IGNORE;
               endcase
            end
            // R12 drive on falling edge
            if (sck_fall && (state == SMC_STREAD || state == SMC_RDATA)) begin
               miso_oe_q <= 1'b1;
               miso_q <= txreg[3'h7 - bitcnt];
            end
         end
      end
   end

   assign link.miso = miso_q;
   assign link.miso_oe = miso_oe_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_view <= 8'h00;
         busy <= 1'b0;
      end else if (clk_en) begin
         status_view <= status_rd;
         busy <= ~sel_n_s;
      end
   end
endmodule : smc_device

// file: rtl/smc_host.sv
// host controller end: apb registers drive one byte per go on the link
module smc_host
   import smc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   smc_link_if.host link
);
   import smc_pkg::*;

   logic [2:0] ctrl;
   logic [7:0] txdata, rxdata, clkdiv, divcnt, sh, rxsh;
   logic [3:0] half;
   logic go, done_flag, sck_q, sel_q;
   logic [1:0] miso_sync;
   smc_host_e st;

   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_ctrl = paddr == REG_CTRL;
   wire hit_stat = paddr == REG_STATUS;
   wire hit_tx = paddr == REG_TXDATA;
   wire hit_rx = paddr == REG_RXDATA;
   wire hit_div = paddr == REG_CLKDIV;
   wire mapped = hit_ctrl | hit_stat | hit_tx | hit_rx | hit_div;
   wire tick = divcnt == 8'h00;
   wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl} :
      hit_stat ? {30'h0, done_flag, st != SMC_IDLE} :
      hit_tx ? {24'h0, txdata} : hit_rx ? {24'h0, rxdata} :
      hit_div ? {24'h0, clkdiv} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 3'h4;
         txdata <= 8'h00;
         clkdiv <= CLKDIV_RESET;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         go <= 1'b0;
      end else if (clk_en) begin
         pready <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         go <= wr & ~pready & hit_ctrl & pwdata[CTRL_GO];
         if (acc && !pready) prdata <= rd_mux;
         if (wr && !pready && hit_ctrl) ctrl <= pwdata[2:0] & 3'h6;
         if (wr && !pready && hit_tx) txdata <= pwdata[7:0];
         if (wr && !pready && hit_div) clkdiv <= pwdata[7:0];
      end
   end

   // ******************************
   // byte shifter, mode 0
   // ******************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= SMC_IDLE;
         divcnt <= 8'h00;
         half <= 4'h0;
         sh <= 8'h00;
         rxsh <= 8'h00;
         rxdata <= 8'h00;
         sck_q <= 1'b0;
         sel_q <= 1'b1;
         done_flag <= 1'b0;
         miso_sync <= 2'b00;
      end else if (clk_en) begin
         miso_sync <= {miso_sync[0], link.miso};
         divcnt <= tick ? clkdiv : divcnt - 8'h01;
         case (st)
            SMC_IDLE: begin
               if (go) begin
                  sh <= txdata;
                  half <= 4'h0;
                  sel_q <= 1'b0;
                  done_flag <= 1'b0;
                  st <= SMC_SHIFT;
               end else if (!ctrl[CTRL_HOLD_SEL]) sel_q <= 1'b1;
            end
            SMC_SHIFT: if (tick) begin
               sck_q <= ~sck_q;
               half <= half + 4'h1;
               // sample at the falling toggle: the answer needs about five
               // pclk through both synchronisers, too late for the rising one
               if (sck_q) begin
                  rxsh <= {rxsh[6:0], miso_sync[1]};
                  sh <= {sh[6:0], 1'b0};
               end
               if (half == 4'hF) st <= SMC_DONE;
            end
            SMC_DONE: begin
               rxdata <= rxsh;
               done_flag <= 1'b1;
               st <= SMC_IDLE;
            end
            default: st <= SMC_IDLE;
         endcase
      end
   end

   assign link.sel_n = sel_q;
   assign link.sck = sck_q;
   assign link.mosi = sh[7];
   assign link.protect_n = ctrl[CTRL_PROTECT_PIN];
endmodule : smc_host

// file: rtl/smc_link_if.sv
// spi link wires between memory device end and host controller end
interface smc_link_if;
   logic sel_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic protect_n;
   modport device (input sel_n, input sck, input mosi, input protect_n,
      output miso, output miso_oe);
   modport host (output sel_n, output sck, output mosi, output protect_n,
      input miso, input miso_oe);
endinterface : smc_link_if

// file: rtl/smc_pkg.sv
// shared constants for the serial memory command link
package smc_pkg;
   // ******************************
   // opcodes
   // ******************************
   localparam logic [7:0] OP_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_LATCH_RESET = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_MEM_READ = 8'h03;
   localparam logic [7:0] OP_MEM_WRITE = 8'h02;
   localparam logic [7:0] OP_ID_READ = 8'h9F;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   // ******************************
   // status register layout
   // ******************************
   localparam int ST_PROTECT_EN = 7;
   localparam int ST_BP_HI = 3;
   localparam int ST_BP_LO = 2;
   localparam int ST_LATCH = 1;
   localparam logic [7:0] ST_NV_MASK = 8'hFC;
   localparam logic [7:0] ST_RESET = 8'h00;
   // ******************************
   // sizes
   // ******************************
   localparam int ADDR_W = 17;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BITS = 8;
   localparam logic [16:0] ADDR_QUARTER = 17'h18000;
   localparam logic [16:0] ADDR_HALF = 17'h10000;
   // ******************************
   // host register map (apb)
   // ******************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0C;
   localparam logic [7:0] REG_CLKDIV = 8'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_HOLD_SEL = 1;
   localparam int CTRL_PROTECT_PIN = 2;
   localparam logic [7:0] CLKDIV_RESET = 8'h04;
   typedef enum logic [1:0] {
      SMC_IDLE = 2'b00,
      SMC_SHIFT = 2'b01,
      SMC_DONE = 2'b10
   } smc_host_e;
endpackage : smc_pkg

// file: sim/smc_link_properties.sv
// link properties checker for the serial memory command link
module smc_link_properties (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link wires
   input wire logic sel_n,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic protect_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // properties
   // ****
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_sck_idle;
      sel_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck moves while deselected");
   property p_sel_low_sck;
      $fell(sel_n) |-> !sck;
   endproperty
   a_sel_low_sck: assert property (p_sel_low_sck) else $error("select falls with sck high");
   // default divider gives five pclk per half period
   property p_sck_high;
      $rose(sck) |-> sck [*5] ##1 !sck;
   endproperty
   a_sck_high: assert property (p_sck_high) else $error("sck high time wrong");
   property p_mosi_hold;
      sck && $past(sck) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moves while sck high");
   property p_miso_hold;
      sck && $past(sck) && miso_oe && $past(miso_oe) |-> $stable(miso);
   endproperty
   a_miso_hold: assert property (p_miso_hold) else $error("miso moves while sck high");
   // miso_oe must stay low for eight pclk after select falls
   property p_no_early_out;
      $fell(sel_n) |-> !miso_oe [*8];
   endproperty
   a_no_early_out: assert property (p_no_early_out) else $error("miso driven too early");
   property p_release;
      sel_n [*5] |-> !miso_oe;
   endproperty
   a_release: assert property (p_release) else $error("miso driven while deselected");
   property p_pin_steady;
      !sel_n && !$past(sel_n) |-> $stable(protect_n);
   endproperty
   a_pin_steady: assert property (p_pin_steady) else $error("protect pin moves in command");
   // ****
   // coverage
   // ****
   c_out: cover property ($rose(miso_oe));
   c_sel: cover property ($fell(sel_n));
   c_pin: cover property (!protect_n && !sel_n);
endmodule : smc_link_properties

// file: sim/spi_serial_memory_commands_bench.sv
// bench driving the host over apb with the device across the link
module spi_serial_memory_commands_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import smc_pkg::*;
   // ****
   // signals
   // ****
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, chk = 0, pin = 1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, bsy;
   logic [7:0] sv;
   logic [32:0] exp_q[$];
   logic [7:0] d[4];
   int seed = 53068, err_total = 0, compares = 0;
   always #4 pclk = ~pclk;
   smc_link_if link();
   smc_host i_smc_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link));
   smc_device i_smc_device (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .link(link),
      .status_view(sv), .busy(bsy));
   smc_link_properties i_smc_link_properties (.pclk(pclk), .presetn(presetn),
      .sel_n(link.sel_n), .sck(link.sck), .mosi(link.mosi), .miso(link.miso),
      .miso_oe(link.miso_oe), .protect_n(link.protect_n));
   // ****
   // checking
   // ****
   task results;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task check(input logic [32:0] got, input logic [32:0] ex);
      compares++;
      if (got !== ex) begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, got, ex);
      end
   endtask : check
   // reads flagged by the driver pop the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && chk) begin
         if (exp_q.size() == 0)
            err_total++;
         else
            check({pslverr, prdata}, exp_q.pop_front());
      end
   end
   // ****
   // drivers
   // ****
   // one idle cycle after each transfer keeps psel to one assignment per step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic c);
      int n;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      chk <= c;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         results();
      end
      r = prdata;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task sb(input logic [7:0] tx, input logic c, input logic [7:0] ex);
      int n;
      apb(1, REG_TXDATA, {24'h0, tx}, 0);
      apb(1, REG_CTRL, {29'h0, pin, 2'b11}, 0);
      n = 0;
      do begin
         apb(0, REG_STATUS, 32'h0, 0);
         n++;
      end while (r[0] !== 1'b0 && n < 200);
      if (r[0] !== 1'b0) begin
         err_total++;
         results();
      end
      if (c) begin
         exp_q.push_back({1'b0, 24'h0, ex});
         apb(0, REG_RXDATA, 32'h0, 1);
      end
   endtask : sb
   task desel;
      apb(1, REG_CTRL, {29'h0, pin, 2'b00}, 0);
   endtask : desel
   task rdst(input logic [7:0] ex);
      sb(OP_STATUS_READ, 0, 0);
      sb(8'($random(seed)), 1, ex);
      check({25'h0, sv}, {25'h0, ex});
      check({32'h0, bsy}, 33'h1);
      desel();
   endtask : rdst
   task wrst(input logic [7:0] v);
      sb(OP_LATCH_SET, 0, 0);
      desel();
      sb(OP_STATUS_WRITE, 0, 0);
      sb(v, 0, 0);
      desel();
   endtask : wrst
   // upper address bits are random since the device drops them
   task adr(input logic [16:0] a);
      logic [31:0] t;
      t = $random(seed);
      sb({t[6:0], a[16]}, 0, 0);
      sb(a[15:8], 0, 0);
      sb(a[7:0], 0, 0);
   endtask : adr
   task wr(input logic lat, input logic [16:0] a, input logic [7:0] b0, input logic [7:0] b1);
      if (lat) begin
         sb(OP_LATCH_SET, 0, 0);
         desel();
      end
      sb(OP_MEM_WRITE, 0, 0);
      adr(a);
      sb(b0, 0, 0);
      sb(b1, 0, 0);
      desel();
   endtask : wr
   task rd(input logic [7:0] op, input logic [16:0] a, input logic [7:0] e0,
      input logic [7:0] e1);
      sb(op, 0, 0);
      adr(a);
      if (op == OP_FAST_READ)
         sb(8'($random(seed)), 0, 0);
      sb(8'($random(seed)), 1, e0);
      sb(8'($random(seed)), 1, e1);
      desel();
   endtask : rd
   // ****
   // scenarios
   // ****
   initial begin
      foreach (d[i]) d[i] = 8'($random(seed));
      repeat (10) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      exp_q.push_back({1'b0, 24'h0, CLKDIV_RESET});
      apb(0, REG_CLKDIV, 32'h0, 1);
      exp_q.push_back({1'b1, 32'h0});
      apb(0, 8'h20, 32'h0, 1);
      rdst(ST_RESET);
      sb(OP_STATUS_WRITE, 0, 0);
      sb(8'hFF, 0, 0);
      desel();
      rdst(8'h00);
      sb(OP_LATCH_SET, 0, 0);
      desel();
      rdst(8'h02);
      wrst(8'hFF);
      rdst(8'hFC);
      pin = 0;
      wrst(8'h00);
      rdst(8'hFC);
      pin = 1;
      wrst(8'h80);
      sb(OP_STATUS_READ, 0, 0);
      sb(8'($random(seed)), 1, 8'h80);
      sb(8'($random(seed)), 1, 8'h80);
      desel();
      wr(1, 17'h1FFFF, d[0], d[1]);
      wr(1, 17'h18000, d[2], d[3]);
      wrst(8'h84);
      rdst(8'h84);
      wr(1, 17'h17FFF, d[3], d[0]);
      wr(0, 17'h00000, ~d[1], ~d[1]);
      rd(OP_MEM_READ, 17'h17FFF, d[3], d[2]);
      rd(OP_FAST_READ, 17'h1FFFF, d[0], d[1]);
      sb(OP_LATCH_SET, 0, 0);
      desel();
      sb(OP_ID_READ, 0, 0);
      sb(8'hFF, 0, 0);
      desel();
      sb(OP_SLEEP, 0, 0);
      desel();
      rdst(8'h86);
      sb(OP_LATCH_RESET, 0, 0);
      desel();
      rdst(8'h84);
      results();
   end
endmodule : spi_serial_memory_commands_bench
